// *** ac_link_dma_sample_regs_bench.sv ***
// Purpose: Self-checking bench for the sample port register slice
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes: Expected words are built from the packing rules, not read back
`timescale 1ns/100ps
module ac_link_dma_sample_regs_bench
    import aclk_pkg::*;
;
    logic clk_sys, resetn, big_endian, reg_wr, reg_rd;
    logic [15:0] reg_addr, tx_slot_a, tx_slot_b;
    logic [15:0] pa, pb, ma, mb;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0] dma_channel_map_sel;
    logic [7:0] chan_enable, pend, clr, req_set;
    logic p0, p1, p2, p3, p4, pcm_in_pop, modem_in_pop;
    int miscompares = 0;
    int checks = 0;
    wire logic [31:0] pushes = {27'h0, p0, p1, p2, p3, p4};

    aclk_dma_sample_regs #(.REV_MAJOR(8'h3c), .REV_MINOR(8'h5a)) i_aclk_dma_sample_regs (
        .clk_sys(clk_sys), .resetn(resetn), .big_endian(big_endian),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dma_channel_map_sel(dma_channel_map_sel),
        .chan_enable(chan_enable), .dma_req_pending(pend), .dma_req_clear(clr),
        .tx_slot_a(tx_slot_a), .tx_slot_b(tx_slot_b), .pcm_out_push(p0),
        .surround_out_push(p1), .center_out_push(p2), .lfe_out_push(p3),
        .modem_out_push(p4), .pcm_in_slot_a(pa), .pcm_in_slot_b(pb),
        .modem_in_slot_a(ma), .modem_in_slot_b(mb), .pcm_in_pop(pcm_in_pop),
        .modem_in_pop(modem_in_pop));

    aclk_far_model i_aclk_far_model (
        .clk_sys(clk_sys), .resetn(resetn), .req_set(req_set), .dma_req_clear(clr),
        .pcm_in_pop(pcm_in_pop), .modem_in_pop(modem_in_pop), .dma_req_pending(pend),
        .pcm_in_slot_a(pa), .pcm_in_slot_b(pb), .modem_in_slot_a(ma),
        .modem_in_slot_b(mb));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Write: one strobe cycle; returns just after the sampling edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read: data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [15:0] a, input logic [31:0] w, output logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Raise one far-side request and let it land
    task automatic raise(input logic [7:0] ch);
        @(posedge clk_sys);
        req_set <= ch;
        @(posedge clk_sys);
        req_set <= 8'h00;
    endtask

    task automatic t_sel();
        logic [31:0] d;
        logic [7:0] map_tab [4] = '{8'h71, 8'h63, 8'h0f, 8'h17};
        chk({24'h0, chan_enable}, 32'h71, "reset map");
        for (int v = 3; v >= 0; v--) begin
            chk({24'h0, pend}, 32'h0, "pending before remap");
            wr_rd(OFS_DMA_MAP_SEL, 32'hffff_fffc | v, d);
            chk(d, v, "selector readback");
            chk({30'h0, dma_channel_map_sel}, v, "selector port");
            chk({24'h0, chan_enable}, {24'h0, map_tab[v]}, "channel map");
        end
    endtask

    task automatic t_out();
        logic [15:0] ofs [5] = '{OFS_PCM_OUT, OFS_SURR_OUT, OFS_CENTER_OUT,
            OFS_LFE_OUT, OFS_MODEM_OUT};
        logic [7:0] chb [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
        logic [15:0] lo, hi;
        for (int e = 0; e < 2; e++) begin
            big_endian <= e[0];
            for (int i = 0; i < 5; i++) begin
                lo = 16'ha000 + i[15:0] + 16'h10 * e[15:0];
                hi = 16'hb000 + i[15:0];
                raise(chb[i]);
                wr(ofs[i], {hi, lo});
                chk(pushes, 32'h10 >> i, "push strobe");
                chk({tx_slot_b, tx_slot_a}, e ? {lo, hi} : {hi, lo}, "slots");
                chk({24'h0, clr}, {24'h0, chb[i]}, "request clear");
            end
        end
    endtask

    task automatic t_in();
        logic [31:0] d, exp;
        for (int e = 0; e < 2; e++) begin
            big_endian <= e[0];
            raise(8'h10);
            exp = e ? {pa, pb} : {pb, pa};
            rd(OFS_PCM_IN, d);
            chk(d, exp, "pcm in word");
            chk({30'h0, pcm_in_pop, modem_in_pop}, 32'h2, "pcm pop");
            chk({24'h0, clr}, 32'h10, "pcm in clear");
            raise(8'h40);
            exp = e ? {ma, mb} : {mb, ma};
            rd(OFS_MODEM_IN, d);
            chk(d, exp, "modem in word");
            chk({30'h0, pcm_in_pop, modem_in_pop}, 32'h1, "modem pop");
            chk({24'h0, clr}, 32'h40, "modem in clear");
        end
        big_endian <= 1'b0;
    endtask

    task automatic t_misc();
        logic [31:0] d;
        rd(OFS_REVISION, d);
        chk(d, 32'h0000_3c5a, "revision word");
        wr(OFS_REVISION, 32'hffff_ffff);
        rd(OFS_REVISION, d);
        chk(d, 32'h0000_3c5a, "revision read-only");
        rd(16'hf7f0, d);
        chk(d, 32'h0, "unmapped read");
        rd(OFS_PCM_OUT, d);
        chk(d, 32'h0, "write-only read");
        wr(OFS_PCM_IN, 32'h1234_5678);
        chk(pushes, 32'h0, "write to input port");
        chk({30'h0, pcm_in_pop, modem_in_pop}, 32'h0, "no pop on write");
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        big_endian = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0;
        reg_wdata = 32'h0;
        req_set = 8'h00;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_sel();
        t_out();
        t_in();
        t_misc();
        end_of_test();
    end

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #(40 * 5000);
        miscompares++;
        end_of_test();
    end
endmodule

// *** aclk_dma_sample_regs.sv ***
// Purpose: Channel map selector, sample data ports and revision word
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: FIFOs and slot timing live outside; ports meet them by strobes
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps

module aclk_dma_sample_regs
    import aclk_pkg::*;
#(
    parameter logic [7:0] REV_MAJOR = REV_MAJOR_DEF,
    parameter logic [7:0] REV_MINOR = REV_MINOR_DEF
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic big_endian,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic [SEL_W-1:0] dma_channel_map_sel,
    output logic [NUM_CH-1:0] chan_enable,
    input wire logic [NUM_CH-1:0] dma_req_pending,
    output logic [NUM_CH-1:0] dma_req_clear,
    output logic [HALF_W-1:0] tx_slot_a,
    output logic [HALF_W-1:0] tx_slot_b,
    output logic pcm_out_push,
    output logic surround_out_push,
    output logic center_out_push,
    output logic lfe_out_push,
    output logic modem_out_push,
    input wire logic [HALF_W-1:0] pcm_in_slot_a,
    input wire logic [HALF_W-1:0] pcm_in_slot_b,
    input wire logic [HALF_W-1:0] modem_in_slot_a,
    input wire logic [HALF_W-1:0] modem_in_slot_b,
    output logic pcm_in_pop,
    output logic modem_in_pop
);
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] next_enable;
    logic [NUM_CH-1:0] port_access;
    logic hit_sel;
    logic hit_rev;
    logic [DATA_W-1:0] wr_swapped;
    logic [DATA_W-1:0] pcm_in_word;
    logic [DATA_W-1:0] modem_in_word;
    logic [DATA_W-1:0] pcm_in_swapped;
    logic [DATA_W-1:0] modem_in_swapped;
    logic [DATA_W-1:0] next_rdata;

    // Address decode, one hit line per sample port
    always_comb begin
        hit = '0;
        hit[CH_PCM_OUT] = (reg_addr == OFS_PCM_OUT);
        hit[CH_SURR_OUT] = (reg_addr == OFS_SURR_OUT);
        hit[CH_CENTER_OUT] = (reg_addr == OFS_CENTER_OUT);
        hit[CH_LFE_OUT] = (reg_addr == OFS_LFE_OUT);
        hit[CH_PCM_IN] = (reg_addr == OFS_PCM_IN);
        hit[CH_MODEM_OUT] = (reg_addr == OFS_MODEM_OUT);
        hit[CH_MODEM_IN] = (reg_addr == OFS_MODEM_IN);
    end
    assign hit_sel = (reg_addr == OFS_DMA_MAP_SEL);
    assign hit_rev = (reg_addr == OFS_REVISION);

    // Output ports take writes, input ports take reads
    always_comb begin
        port_access = '0;
        port_access[CH_PCM_OUT] = reg_wr & hit[CH_PCM_OUT];
        port_access[CH_SURR_OUT] = reg_wr & hit[CH_SURR_OUT];
        port_access[CH_CENTER_OUT] = reg_wr & hit[CH_CENTER_OUT];
        port_access[CH_LFE_OUT] = reg_wr & hit[CH_LFE_OUT];
        port_access[CH_MODEM_OUT] = reg_wr & hit[CH_MODEM_OUT];
        port_access[CH_PCM_IN] = reg_rd & hit[CH_PCM_IN];
        port_access[CH_MODEM_IN] = reg_rd & hit[CH_MODEM_IN];
    end

    // Selector register; upper bits of the word are dropped
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dma_channel_map_sel <= SEL_RESET;
        end else if (reg_wr && hit_sel) begin
            dma_channel_map_sel <= reg_wdata[SEL_LSB +: SEL_W];
        end
    end

    // Channel mapping; remapping mid-transfer is software's hazard
    always_comb begin
        case (dma_channel_map_sel)
            SEL_MODE0: next_enable = MAP_MODE0;
            SEL_MODE1: next_enable = MAP_MODE1;
            SEL_MODE2: next_enable = MAP_MODE2;
            SEL_MODE3: next_enable = MAP_MODE3;
            default: next_enable = MAP_MODE0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chan_enable <= MAP_MODE0;
        end else begin
            chan_enable <= next_enable;
        end
    end

    // Request clear: each port access clears its pending request
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_clr
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    dma_req_clear[gi] <= 1'b0;
                end else begin
                    dma_req_clear[gi] <= port_access[gi] & dma_req_pending[gi];
                end
            end
        end
    endgenerate

    // Write-side halves exchanged per endian mode
    aclk_half_swap u_wr_swap (
        .big_endian(big_endian),
        .word_in(reg_wdata),
        .word_out(wr_swapped)
    );

    // Sample halves and push strobes towards the transmit FIFOs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_slot_a <= HALF_ZERO;
            tx_slot_b <= HALF_ZERO;
            pcm_out_push <= 1'b0;
            surround_out_push <= 1'b0;
            center_out_push <= 1'b0;
            lfe_out_push <= 1'b0;
            modem_out_push <= 1'b0;
        end else begin
            if (reg_wr && (hit[CH_PCM_OUT] || hit[CH_SURR_OUT] || hit[CH_CENTER_OUT]
                    || hit[CH_LFE_OUT] || hit[CH_MODEM_OUT])) begin
                tx_slot_a <= wr_swapped[LO_LSB +: HALF_W];
                tx_slot_b <= wr_swapped[HI_LSB +: HALF_W];
            end
            pcm_out_push <= port_access[CH_PCM_OUT];
            surround_out_push <= port_access[CH_SURR_OUT];
            center_out_push <= port_access[CH_CENTER_OUT];
            lfe_out_push <= port_access[CH_LFE_OUT];
            modem_out_push <= port_access[CH_MODEM_OUT];
        end
    end

    // Receive words assembled little-endian, then swapped as needed
    assign pcm_in_word = {pcm_in_slot_b, pcm_in_slot_a};
    assign modem_in_word = {modem_in_slot_b, modem_in_slot_a};

    aclk_half_swap u_pcm_in_swap (
        .big_endian(big_endian),
        .word_in(pcm_in_word),
        .word_out(pcm_in_swapped)
    );

    aclk_half_swap u_modem_in_swap (
        .big_endian(big_endian),
        .word_in(modem_in_word),
        .word_out(modem_in_swapped)
    );

    // Read mux; write-only and unmapped addresses read zero
    always_comb begin
        next_rdata = RDATA_RESET;
        if (hit_sel) begin
            next_rdata[SEL_LSB +: SEL_W] = dma_channel_map_sel;
        end else if (hit[CH_PCM_IN]) begin
            next_rdata = pcm_in_swapped;
        end else if (hit[CH_MODEM_IN]) begin
            next_rdata = modem_in_swapped;
        end else if (hit_rev) begin
            next_rdata[REV_MAJOR_LSB +: 8] = REV_MAJOR;
            next_rdata[REV_MINOR_LSB +: 8] = REV_MINOR;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= RDATA_RESET;
            pcm_in_pop <= 1'b0;
            modem_in_pop <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : RDATA_RESET;
            pcm_in_pop <= port_access[CH_PCM_IN];
            modem_in_pop <= port_access[CH_MODEM_IN];
        end
    end

    // Assertions
    sequence s_sel_write;
        reg_wr && hit_sel;
    endsequence

    sequence s_sel_read;
        reg_rd && hit_sel;
    endsequence

    AST_SEL_READBACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sel_write ##1 s_sel_read |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)})
        else $error("selector read back wrong");

    AST_MAP_MODE2: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dma_channel_map_sel == SEL_MODE2) |=> chan_enable == MAP_MODE2)
        else $error("map mode 2 channels wrong");

    AST_MAP_FOLLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sel_write |=> ##1 chan_enable[CH_PCM_OUT] && chan_enable[CH_SPARE] == 1'b0)
        else $error("channel map lost pcm out");

    AST_PCM_OUT_PACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_PCM_OUT] && !big_endian |=>
        pcm_out_push && tx_slot_a == $past(reg_wdata[15:0]) && tx_slot_b == $past(reg_wdata[31:16]))
        else $error("pcm out little endian packing wrong");

    AST_MODEM_OUT_BE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_MODEM_OUT] && big_endian |=>
        modem_out_push && tx_slot_a == $past(reg_wdata[31:16]))
        else $error("modem out big endian packing wrong");

    AST_PCM_IN_PACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && hit[CH_PCM_IN] |=> pcm_in_pop && reg_rdata[15:0] ==
        ($past(big_endian) ? $past(pcm_in_slot_b) : $past(pcm_in_slot_a)))
        else $error("pcm in packing wrong");

    AST_MODEM_IN_PACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && hit[CH_MODEM_IN] |=> reg_rdata[31:16] ==
        ($past(big_endian) ? $past(modem_in_slot_a) : $past(modem_in_slot_b)))
        else $error("modem in packing wrong");

    AST_REVISION: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && hit_rev |=> reg_rdata == {16'h0, REV_MAJOR, REV_MINOR})
        else $error("revision word wrong");

    AST_REQ_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
        port_access[CH_LFE_OUT] && dma_req_pending[CH_LFE_OUT] |=>
        dma_req_clear[CH_LFE_OUT] ##1 !dma_req_clear[CH_LFE_OUT] || $past(port_access[CH_LFE_OUT]))
        else $error("lfe request clear wrong");

    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && (hit_sel || hit_rev) |=> reg_rdata[31:16] == 16'h0)
        else $error("reserved bits not zero");

    sequence s_out_read;
        reg_rd && (hit[CH_PCM_OUT] || hit[CH_SURR_OUT] || hit[CH_CENTER_OUT]
            || hit[CH_LFE_OUT] || hit[CH_MODEM_OUT]);
    endsequence

    AST_WO_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_out_read |=> reg_rdata == RDATA_RESET)
        else $error("write-only port read not zero");

    AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
        !reg_rd |=> reg_rdata == RDATA_RESET)
        else $error("read data outside read cycle");

    AST_SEL_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sel_write |=> dma_channel_map_sel == $past(reg_wdata[SEL_LSB +: SEL_W]))
        else $error("selector write lost");

    AST_SEL_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(reg_wr && hit_sel) |=> $stable(dma_channel_map_sel))
        else $error("selector changed without write");

    AST_MAP_MODE0: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dma_channel_map_sel == SEL_MODE0) |=> chan_enable == MAP_MODE0)
        else $error("map mode 0 channels wrong");

    AST_MAP_MODE1: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dma_channel_map_sel == SEL_MODE1) |=> chan_enable == MAP_MODE1)
        else $error("map mode 1 channels wrong");

    AST_MAP_MODE3: assert property (@(posedge clk_sys) disable iff (!resetn)
        (dma_channel_map_sel == SEL_MODE3) |=> chan_enable == MAP_MODE3)
        else $error("map mode 3 channels wrong");

    AST_PCM_OUT_BE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_PCM_OUT] && big_endian |=> pcm_out_push
        && tx_slot_a == $past(reg_wdata[31:16]) && tx_slot_b == $past(reg_wdata[15:0]))
        else $error("pcm out big endian packing wrong");

    AST_SURR_OUT_LE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_SURR_OUT] && !big_endian |=> surround_out_push
        && tx_slot_a == $past(reg_wdata[15:0]) && tx_slot_b == $past(reg_wdata[31:16]))
        else $error("surround out little endian packing wrong");

    AST_CENTER_OUT_BE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_CENTER_OUT] && big_endian |=> center_out_push
        && tx_slot_a == $past(reg_wdata[31:16]) && tx_slot_b == $past(reg_wdata[15:0]))
        else $error("center out big endian packing wrong");

    AST_LFE_OUT_LE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_LFE_OUT] && !big_endian |=> lfe_out_push
        && tx_slot_a == $past(reg_wdata[15:0]) && tx_slot_b == $past(reg_wdata[31:16]))
        else $error("lfe out little endian packing wrong");

    AST_MODEM_OUT_LE: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && hit[CH_MODEM_OUT] && !big_endian |=> modem_out_push
        && tx_slot_a == $past(reg_wdata[15:0]) && tx_slot_b == $past(reg_wdata[31:16]))
        else $error("modem out little endian packing wrong");

    AST_PCM_IN_HIGH: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && hit[CH_PCM_IN] |=> reg_rdata[31:16] ==
        ($past(big_endian) ? $past(pcm_in_slot_a) : $past(pcm_in_slot_b)))
        else $error("pcm in upper half wrong");

    AST_MODEM_IN_LOW: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && hit[CH_MODEM_IN] |=> modem_in_pop && reg_rdata[15:0] ==
        ($past(big_endian) ? $past(modem_in_slot_b) : $past(modem_in_slot_a)))
        else $error("modem in lower half wrong");

    AST_REQ_CLEAR_PCM_IN: assert property (@(posedge clk_sys) disable iff (!resetn)
        port_access[CH_PCM_IN] && dma_req_pending[CH_PCM_IN] |=>
        dma_req_clear[CH_PCM_IN] && pcm_in_pop)
        else $error("pcm in request clear wrong");

    AST_CLR_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
        dma_req_clear[CH_MODEM_OUT] |->
        $past(reg_wr && hit[CH_MODEM_OUT] && dma_req_pending[CH_MODEM_OUT]))
        else $error("modem out clear without access");

    AST_PUSH_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
        modem_out_push |-> $past(reg_wr && hit[CH_MODEM_OUT]))
        else $error("modem out push without write");

    AST_POP_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
        pcm_in_pop |-> $past(reg_rd && hit[CH_PCM_IN]))
        else $error("pcm in pop without read");
endmodule

// *** aclk_far_model.sv ***
// Purpose: Far-side model of the sample FIFO heads and DMA request flags
// Assumes: Same clock and reset as the register slice
// Notes: Heads count up per pop, so a missed or extra pop shows in data
`timescale 1ns/100ps
module aclk_far_model
    import aclk_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [NUM_CH-1:0] req_set,
    input wire logic [NUM_CH-1:0] dma_req_clear,
    input wire logic pcm_in_pop,
    input wire logic modem_in_pop,
    output logic [NUM_CH-1:0] dma_req_pending,
    output logic [HALF_W-1:0] pcm_in_slot_a,
    output logic [HALF_W-1:0] pcm_in_slot_b,
    output logic [HALF_W-1:0] modem_in_slot_a,
    output logic [HALF_W-1:0] modem_in_slot_b
);
    logic [7:0] pcm_cnt;
    logic [7:0] mod_cnt;

    // A request stays up until one port access clears it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dma_req_pending <= '0;
        end else begin
            dma_req_pending <= (dma_req_pending & ~dma_req_clear) | req_set;
        end
    end

    // Each pop moves the head to a fresh sample pair
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pcm_cnt <= 8'h00;
            mod_cnt <= 8'h00;
        end else begin
            pcm_cnt <= pcm_cnt + {7'h00, pcm_in_pop};
            mod_cnt <= mod_cnt + {7'h00, modem_in_pop};
        end
    end

    // Distinct upper bytes keep the two halves apart
    assign pcm_in_slot_a = {8'h1a, pcm_cnt};
    assign pcm_in_slot_b = {8'h2b, pcm_cnt};
    assign modem_in_slot_a = {8'h3c, mod_cnt};
    assign modem_in_slot_b = {8'h4d, mod_cnt};
endmodule

// *** aclk_half_swap.sv ***
// Purpose: Endian-dependent exchange of the two 16-bit sample halves
// Assumes: Pure combinational, same clock as the caller
// Notes: Shared by write and read paths alike
`timescale 1ns/100ps
module aclk_half_swap
    import aclk_pkg::*;
(
    input wire logic big_endian,
    input wire logic [DATA_W-1:0] word_in,
    output logic [DATA_W-1:0] word_out
);
    // Little endian keeps slot a low; big endian moves it high
    always_comb begin
        if (big_endian) begin
            word_out = {word_in[LO_LSB +: HALF_W], word_in[HI_LSB +: HALF_W]};
        end else begin
            word_out = word_in;
        end
    end
endmodule

// *** aclk_pkg.sv ***
// Purpose: Constants for the audio link DMA sample port register slice
// Assumes: Byte addresses on a plain register port, 32-bit data
// Notes: Offsets are byte addresses within the controller window
package aclk_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned NUM_CH = 8;

    // Register byte offsets
    localparam logic [15:0] OFS_DMA_MAP_SEL = 16'hf784;
    localparam logic [15:0] OFS_PCM_OUT = 16'hf7a0;
    localparam logic [15:0] OFS_SURR_OUT = 16'hf7a4;
    localparam logic [15:0] OFS_CENTER_OUT = 16'hf7a8;
    localparam logic [15:0] OFS_LFE_OUT = 16'hf7ac;
    localparam logic [15:0] OFS_PCM_IN = 16'hf7b0;
    localparam logic [15:0] OFS_MODEM_OUT = 16'hf7b8;
    localparam logic [15:0] OFS_MODEM_IN = 16'hf7bc;
    localparam logic [15:0] OFS_REVISION = 16'hf7fc;

    // Field positions
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned LO_LSB = 0;
    localparam int unsigned HI_LSB = 16;
    localparam int unsigned REV_MINOR_LSB = 0;
    localparam int unsigned REV_MAJOR_LSB = 8;

    // Reset values
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;

    // Arbitrary revision values, not tied to any real part
    localparam logic [7:0] REV_MAJOR_DEF = 8'h01;
    localparam logic [7:0] REV_MINOR_DEF = 8'h00;

    // Channel index order in the request and enable vectors
    localparam int unsigned CH_PCM_OUT = 0;
    localparam int unsigned CH_SURR_OUT = 1;
    localparam int unsigned CH_CENTER_OUT = 2;
    localparam int unsigned CH_LFE_OUT = 3;
    localparam int unsigned CH_PCM_IN = 4;
    localparam int unsigned CH_MODEM_OUT = 5;
    localparam int unsigned CH_MODEM_IN = 6;
    localparam int unsigned CH_SPARE = 7;

    // Channel enable pattern per map selector value
    localparam logic [7:0] MAP_MODE0 = 8'h71;
    localparam logic [7:0] MAP_MODE1 = 8'h63;
    localparam logic [7:0] MAP_MODE2 = 8'h0f;
    localparam logic [7:0] MAP_MODE3 = 8'h17;

    localparam logic [1:0] SEL_MODE0 = 2'h0;
    localparam logic [1:0] SEL_MODE1 = 2'h1;
    localparam logic [1:0] SEL_MODE2 = 2'h2;
    localparam logic [1:0] SEL_MODE3 = 2'h3;
endpackage
